// ---- dv/sterp_host.sv ----
// Host model: query, enable write and clear strobes.
// Assumes the core takes strobes on rising clk_sys_i.
`timescale 1ns/1ps
`default_nettype none
module sterp_host
    import sterp_pkg::*;
(
    // Clock
    input  wire logic        clk_sys_i,
    // Strobes
    output logic             query_o,
    output logic             write_o,
    output logic             clear_o,
    output logic             arm_o,
    output logic [2:0]       sel_o,
    output logic [7:0]       wdata_o,
    // Replies
    input  wire logic        rvalid_i,
    input  wire logic [7:0]  rbin_i,
    input  wire logic [11:0] rdec_i
);
    initial begin
        {query_o, write_o, clear_o, arm_o} = 4'h0;
        sel_o = 3'h7;
        wdata_o = 8'h00;
    end
    // Decimal argument split into weights 128 down to 1
    task automatic put(input logic [2:0] s, input int dec);
        @(posedge clk_sys_i);
        #1;
        for (int b = 7; b >= 0; b--) begin
            wdata_o[b] = (dec >= (1 << b));
            dec = wdata_o[b] ? dec - (1 << b) : dec;
        end
        sel_o = s;
        write_o = 1'b1;
        @(posedge clk_sys_i);
        #1;
        write_o = 1'b0;
        sel_o = ~s;
        wdata_o = ~wdata_o;
    endtask : put
    task automatic ask(input logic [2:0] s, output logic v, output logic [7:0] b, output logic [11:0] d);
        @(posedge clk_sys_i);
        #1;
        query_o = 1'b1;
        sel_o = s;
        @(posedge clk_sys_i);
        #1;
        query_o = 1'b0;
        sel_o = ~s;
        v = rvalid_i;
        b = rbin_i;
        d = rdec_i;
    endtask : ask
    // Clear when clr, else the completion-arm command
    task automatic pulse(input logic clr);
        @(posedge clk_sys_i);
        #1;
        clear_o = clr;
        arm_o = ~clr;
        @(posedge clk_sys_i);
        #1;
        {clear_o, arm_o} = 2'b00;
    endtask : pulse
endmodule : sterp_host
`default_nettype wire

// ---- dv/test_status_event_reporting.sv ----
// Testbench of the status event core driven through the host model.
// Assumes a 25 MHz clock and a one-cycle query reply.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin failures++; $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module test_status_event_reporting import sterp_pkg::*;;
    logic        clk_sys_i = 1'b0;
    logic        nrst_i = 1'b0;
    logic [2:0]  flt = 3'h0;
    logic        pend = 1'b0;
    logic        mav = 1'b1;
    logic [7:0]  cond = 8'h00;
    logic        qry, wr, clr, arm, rv, esum, osum;
    logic [2:0]  sel;
    logic [7:0]  wd, rb, latch, stb;
    logic [11:0] rd;
    int          failures = 0;
    int          check_count = 0;
    int          cyc = 0;
    always #20 clk_sys_i = ~clk_sys_i;
    sterp_core dut_u (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .command_fault_flag_i(flt[0]),
        .run_fault_flag_i(flt[1]), .query_fault_flag_i(flt[2]), .ops_pending_i(pend), .oper_cond_i(cond),
        .msg_avail_i(mav), .clear_status_i(clr), .ops_done_cmd_i(arm), .query_i(qry), .write_i(wr),
        .sel_i(sel), .wdata_i(wd), .reply_valid_o(rv), .reply_bin_o(rb), .reply_dec_o(rd),
        .std_event_latch_o(latch), .status_byte_o(stb), .event_summary_bit_o(esum), .oper_summary_o(osum));
    sterp_host host_u (.clk_sys_i(clk_sys_i), .query_o(qry), .write_o(wr), .clear_o(clr), .arm_o(arm),
        .sel_o(sel), .wdata_o(wd), .rvalid_i(rv), .rbin_i(rb), .rdec_i(rd));
    task automatic results();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : results
    // Generous ceiling; the run needs about 80 cycles
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 3000) begin
            failures++;
            results();
        end
    end
    task automatic settle();
        @(posedge clk_sys_i);
        #1;
    endtask : settle
    task automatic raise(input logic [2:0] f);
        settle();
        flt = f;
        settle();
        flt = 3'h0;
    endtask : raise
    task automatic expect_reg(input logic [2:0] s, input logic [7:0] e);
        logic v;
        logic [7:0] b;
        logic [11:0] d;
        logic [11:0] x;
        x = {4'(e / 100), 4'(e / 10 % 10), 4'(e % 10)};
        host_u.ask(s, v, b, d);
        `CHK("reply_valid", 1'b1, v)
        `CHK("reply_bin", e, b)
        `CHK("reply_dec", x, d)
    endtask : expect_reg
    task automatic t_power_up();
        repeat (2) settle();
        `CHK("latch", 8'h80, latch)
        `CHK("status_byte", 8'h10, stb)
        expect_reg(SEL_STD_ENABLE, 8'h00);
        expect_reg(SEL_OPR_ENABLE, 8'h00);
        expect_reg(SEL_SRQ_ENABLE, 8'h00);
        expect_reg(SEL_STD_EVENT, 8'h80);
        `CHK("latch", 8'h00, latch)
    endtask : t_power_up
    task automatic t_events();
        pend = 1'b1;
        host_u.pulse(1'b0);
        raise(3'h7);
        raise(3'h7);
        `CHK("latch", 8'h34, latch)
        pend = 1'b0;
        repeat (3) settle();
        `CHK("latch", 8'h35, latch)
        `CHK("summary", 1'b0, esum)
    endtask : t_events
    task automatic t_enable();
        host_u.put(SEL_STD_ENABLE, 32);
        expect_reg(SEL_STD_ENABLE, 8'h20);
        `CHK("summary", 1'b1, esum)
        `CHK("sb_event", 1'b1, stb[SB_EVENT_SUM])
        host_u.put(SEL_STD_ENABLE, 2);
        settle();
        `CHK("summary", 1'b0, esum)
        host_u.put(SEL_STD_ENABLE, 149);
        settle();
        `CHK("summary", 1'b1, esum)
        expect_reg(SEL_STD_EVENT, 8'h35);
        `CHK("summary", 1'b0, esum)
        `CHK("sb_event", 1'b0, stb[SB_EVENT_SUM])
        host_u.put(SEL_STD_ENABLE, 0);
        expect_reg(SEL_STD_ENABLE, 8'h00);
    endtask : t_enable
    task automatic t_read_only();
        raise(3'h1);
        host_u.put(SEL_STD_EVENT, 0);
        host_u.put(SEL_STAT_BYTE, 0);
        host_u.put(SEL_OPR_COND, 255);
        `CHK("latch", 8'h20, latch)
        `CHK("status_byte", 8'h10, stb)
        cond = 8'h5A;
        expect_reg(SEL_OPR_COND, 8'h5A);
        cond = 8'h5B;
        expect_reg(SEL_OPR_COND, 8'h5B);
    endtask : t_read_only
    task automatic t_clear();
        host_u.put(SEL_OPR_ENABLE, 255);
        host_u.put(SEL_STD_ENABLE, 32);
        settle();
        `CHK("status_byte", 8'hB0, stb)
        host_u.pulse(1'b1);
        `CHK("status_byte", 8'h10, stb)
        `CHK("oper_summary", 1'b0, osum)
        `CHK("latch", 8'h00, latch)
        expect_reg(SEL_OPR_EVENT, 8'h00);
        expect_reg(SEL_OPR_COND, 8'h5B);
    endtask : t_clear
    initial begin
        repeat (20) @(posedge clk_sys_i);
        #1;
        nrst_i = 1'b1;
        t_power_up();
        t_events();
        t_enable();
        t_read_only();
        t_clear();
        results();
    end
endmodule : test_status_event_reporting
`default_nettype wire

// ---- logic/sterp_core.sv ----
// Status event reporting core: standard and operation event sets, their
// enables, the status byte and decimal-weighted query answers.
// Assumes commands arrive as one-cycle strobes from a decoder in clk_sys_i.
`timescale 1ns/1ps
`default_nettype none
module sterp_core
    import sterp_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        nrst_i,
    // Event sources
    input  wire logic        command_fault_flag_i,
    input  wire logic        run_fault_flag_i,
    input  wire logic        query_fault_flag_i,
    input  wire logic        ops_pending_i,
    input  wire logic [7:0]  oper_cond_i,
    input  wire logic        msg_avail_i,
    // Command strobes
    input  wire logic        clear_status_i,
    input  wire logic        ops_done_cmd_i,
    input  wire logic        query_i,
    input  wire logic        write_i,
    input  wire logic [2:0]  sel_i,
    input  wire logic [7:0]  wdata_i,
    // Answers
    output logic             reply_valid_o,
    output logic [7:0]       reply_bin_o,
    output logic [11:0]      reply_dec_o,
    output logic [7:0]       std_event_latch_o,
    output logic [7:0]       status_byte_o,
    output logic             event_summary_bit_o,
    output logic             oper_summary_o
);
    typedef struct packed {
        sterp_state_t state;
        logic [7:0]   std_event_latch;
        logic [7:0]   std_enable;
        logic [7:0]   opr_event;
        logic [7:0]   opr_enable;
        logic [7:0]   srq_enable;
        logic [7:0]   opr_cond_q;
        logic         power_up_pend;
        logic         ops_armed;
        logic [7:0]   reply_bin;
        logic [11:0]  reply_dec;
    } sterp_regs_t;

    sterp_regs_t r;
    sterp_regs_t next_r;

    // Binary to three BCD digits by double dabble
    function automatic logic [11:0] to_decimal(input logic [7:0] v);
        logic [19:0] acc;
        acc = {12'h000, v};
        for (int i = 0; i < 8; i++) begin
            if (acc[11:8] > 4'h4) begin
                acc[11:8] = acc[11:8] + 4'h3;
            end
            if (acc[15:12] > 4'h4) begin
                acc[15:12] = acc[15:12] + 4'h3;
            end
            if (acc[19:16] > 4'h4) begin
                acc[19:16] = acc[19:16] + 4'h3;
            end
            acc = {acc[18:0], 1'b0};
        end
        return acc[19:8];
    endfunction : to_decimal

    logic       std_sum;
    logic       opr_sum;
    logic [7:0] stat_byte;
    logic [7:0] std_set;
    logic [7:0] opr_rise;
    logic       rd_std;

    // Summaries are combinational so they fall with their event register
    assign std_sum = |(r.std_event_latch & r.std_enable & STD_USED_MASK);
    assign opr_sum = |(r.opr_event & r.opr_enable);
    always_comb begin
        stat_byte = RST_ZERO;
        stat_byte[SB_OPER_SUM] = opr_sum;
        stat_byte[SB_EVENT_SUM] = std_sum;
        stat_byte[4] = msg_avail_i;
        stat_byte[6] = |({opr_sum, 1'b0, std_sum, msg_avail_i, 4'h0} & r.srq_enable);
    end

    assign rd_std = query_i && (sel_i == SEL_STD_EVENT);
    assign opr_rise = oper_cond_i & ~r.opr_cond_q;

    always_comb begin
        std_set = RST_ZERO;
        std_set[BIT_POWER_UP]  = r.power_up_pend;
        std_set[BIT_CMD_FAULT] = command_fault_flag_i;
        std_set[BIT_RUN_FAULT] = run_fault_flag_i;
        std_set[BIT_QRY_FAULT] = query_fault_flag_i;
        std_set[BIT_OPS_DONE]  = r.ops_armed && !ops_pending_i;
    end

    always_comb begin
        next_r = r;
        next_r.opr_cond_q = oper_cond_i;
        next_r.power_up_pend = 1'b0;
        next_r.state = ST_IDLE;
        // Arming survives queries; the query form of complete never touches it
        if (ops_done_cmd_i) begin
            next_r.ops_armed = 1'b1;
        end else if (r.ops_armed && !ops_pending_i) begin
            next_r.ops_armed = 1'b0;
        end
        // Clears first, then sets, so an event in the clear cycle is kept
        if (clear_status_i) begin
            next_r.std_event_latch = RST_ZERO;
            next_r.opr_event = RST_ZERO;
        end else if (rd_std) begin
            next_r.std_event_latch = RST_ZERO;
        end
        next_r.std_event_latch = next_r.std_event_latch | (std_set & STD_USED_MASK);
        next_r.opr_event = next_r.opr_event | opr_rise;
        // Only enable registers take writes; zero clears them
        if (write_i) begin
            if (sel_i == SEL_STD_ENABLE) begin
                next_r.std_enable = wdata_i;
            end else if (sel_i == SEL_OPR_ENABLE) begin
                next_r.opr_enable = wdata_i;
            end else if (sel_i == SEL_SRQ_ENABLE) begin
                next_r.srq_enable = wdata_i & 8'hBF;
            end
        end
        if (query_i) begin
            next_r.state = ST_REPLY;
            if (sel_i == SEL_STD_EVENT) begin
                next_r.reply_bin = r.std_event_latch & STD_USED_MASK;
            end else if (sel_i == SEL_STD_ENABLE) begin
                next_r.reply_bin = r.std_enable;
            end else if (sel_i == SEL_OPR_EVENT) begin
                next_r.reply_bin = r.opr_event;
            end else if (sel_i == SEL_OPR_ENABLE) begin
                next_r.reply_bin = r.opr_enable;
            end else if (sel_i == SEL_OPR_COND) begin
                next_r.reply_bin = oper_cond_i;
            end else if (sel_i == SEL_SRQ_ENABLE) begin
                next_r.reply_bin = r.srq_enable;
            end else if (sel_i == SEL_STAT_BYTE) begin
                next_r.reply_bin = stat_byte;
            end else begin
                next_r.reply_bin = RST_ZERO;
            end
            next_r.reply_dec = to_decimal(next_r.reply_bin);
        end
    end

    // Power-up flag pends one cycle after release to mark the off-on edge
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            r.state           <= ST_IDLE;
            r.std_event_latch <= RST_ZERO;
            r.std_enable      <= RST_ZERO;
            r.opr_event       <= RST_ZERO;
            r.opr_enable      <= RST_ZERO;
            r.srq_enable      <= RST_ZERO;
            r.opr_cond_q      <= RST_ZERO;
            r.power_up_pend   <= 1'b1;
            r.ops_armed       <= 1'b0;
            r.reply_bin       <= RST_ZERO;
            r.reply_dec       <= 12'h000;
        end else begin
            r <= next_r;
        end
    end

    assign reply_valid_o       = (r.state == ST_REPLY);
    assign reply_bin_o         = r.reply_bin;
    assign reply_dec_o         = r.reply_dec;
    assign std_event_latch_o   = r.std_event_latch;
    assign status_byte_o       = stat_byte;
    assign event_summary_bit_o = std_sum;
    assign oper_summary_o      = opr_sum;

    // Assertions
    sequence s_std_query;
        query_i && sel_i == SEL_STD_EVENT && !clear_status_i;
    endsequence
    sequence s_no_new_std;
        std_set == RST_ZERO;
    endsequence

    chk_query_clears_std: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        s_std_query ##0 s_no_new_std |=> reply_valid_o && std_event_latch_o == RST_ZERO
            && reply_bin_o == ($past(std_event_latch_o) & STD_USED_MASK))
        else $error("event query did not return then clear");
    chk_clear_status_all: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        clear_status_i ##0 s_no_new_std ##0 (opr_rise == RST_ZERO) |=> !event_summary_bit_o && !oper_summary_o)
        else $error("clear status left a summary set");
    chk_latch_holds: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        !clear_status_i && !rd_std |=> (std_event_latch_o & $past(std_event_latch_o)) == $past(std_event_latch_o))
        else $error("event bit dropped without clear");
    chk_summary_and: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        status_byte_o[SB_EVENT_SUM] == |(std_event_latch_o & r.std_enable))
        else $error("event summary mismatch");
    chk_unused_zero: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (std_event_latch_o & ~STD_USED_MASK) == RST_ZERO)
        else $error("unused event bit set");
    chk_cmd_fault_set: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        command_fault_flag_i |=> std_event_latch_o[BIT_CMD_FAULT])
        else $error("command fault not latched");
    chk_enable_write: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        write_i && sel_i == SEL_STD_ENABLE ##1 query_i && sel_i == SEL_STD_ENABLE && !write_i
            |=> reply_bin_o == $past(wdata_i, 2))
        else $error("enable readback mismatch");
    chk_ro_ignored: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        write_i && sel_i == SEL_STD_EVENT && !clear_status_i && !rd_std |=> std_event_latch_o ==
            ($past(std_event_latch_o) | ($past(std_set) & STD_USED_MASK)))
        else $error("write altered read-only register");
    chk_ops_done: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        r.ops_armed && !ops_pending_i |=> std_event_latch_o[BIT_OPS_DONE])
        else $error("ops done not set");
    chk_decimal_reply: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        reply_valid_o |-> reply_dec_o[11:8] * 100 + reply_dec_o[7:4] * 10 + reply_dec_o[3:0] == reply_bin_o)
        else $error("decimal reply wrong");
    chk_decimal_digits: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        reply_dec_o[3:0] <= 4'h9 && reply_dec_o[7:4] <= 4'h9 && reply_dec_o[11:8] <= 4'h2)
        else $error("decimal digit out of range");
    chk_reply_pulse: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        !query_i |=> !reply_valid_o)
        else $error("reply valid without query");
    chk_reply_holds: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        !query_i |=> $stable(reply_bin_o) && $stable(reply_dec_o))
        else $error("reply changed without query");

    // Event sources; each one must reach its own latch bit, and completion arms only on its command
    chk_run_fault_set: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        run_fault_flag_i |=> std_event_latch_o[BIT_RUN_FAULT])
        else $error("run fault not latched");
    chk_qry_fault_set: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        query_fault_flag_i |=> std_event_latch_o[BIT_QRY_FAULT])
        else $error("query fault not latched");
    chk_power_up_set: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        r.power_up_pend |=> std_event_latch_o[BIT_POWER_UP])
        else $error("power up not latched");
    chk_ops_arm_hold: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        !ops_done_cmd_i && !r.ops_armed |=> !r.ops_armed)
        else $error("completion armed without command");

    // Per-bit checks; used and unused bits need opposite guarantees
    for (genvar g = 0; g < REG_W; g++) begin : g_bit_chk
        if (STD_USED_MASK[g]) begin : g_used
            chk_bit_sticky: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
                std_event_latch_o[g] && !clear_status_i && !rd_std |=> std_event_latch_o[g])
                else $error("used event bit dropped");
            chk_bit_sets: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
                std_set[g] |=> std_event_latch_o[g])
                else $error("event bit not latched");
        end else begin : g_unused
            chk_bit_unused: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
                !std_event_latch_o[g])
                else $error("unused event bit set");
            chk_bit_reads_zero: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
                rd_std |=> !reply_bin_o[g])
                else $error("unused event bit read as one");
        end
    end

    // Enable writes, including the zero that clears them
    sequence s_std_en_write;
        write_i && sel_i == SEL_STD_ENABLE;
    endsequence
    sequence s_zero_data;
        wdata_i == RST_ZERO;
    endsequence

    chk_std_enable_zero: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        s_std_en_write ##0 s_zero_data |=> r.std_enable == RST_ZERO)
        else $error("zero write left enable bits");
    chk_opr_enable_zero: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        write_i && sel_i == SEL_OPR_ENABLE ##0 s_zero_data |=> r.opr_enable == RST_ZERO)
        else $error("zero write left operation enables");
    chk_opr_enable_write: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        write_i && sel_i == SEL_OPR_ENABLE |=> r.opr_enable == $past(wdata_i))
        else $error("operation enable not written");
    chk_srq_bit6_zero: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        !r.srq_enable[6])
        else $error("request enable bit 6 set");

    // Condition and operation event behaviour
    chk_cond_live: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        query_i && sel_i == SEL_OPR_COND |=> reply_bin_o == $past(oper_cond_i))
        else $error("condition reply not live");
    chk_opr_latch: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        opr_rise != RST_ZERO |=> (r.opr_event & $past(opr_rise)) == $past(opr_rise))
        else $error("operation event not latched");
    chk_clear_opr: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        clear_status_i && opr_rise == RST_ZERO |=> r.opr_event == RST_ZERO)
        else $error("clear status left operation events");

    // Status byte layout; no bit of it is stored
    chk_esb_position: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        status_byte_o[SB_EVENT_SUM] == event_summary_bit_o)
        else $error("event summary misplaced");
    chk_osb_position: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        status_byte_o[SB_OPER_SUM] == oper_summary_o)
        else $error("operation summary misplaced");
    chk_oper_summary: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        oper_summary_o == |(r.opr_event & r.opr_enable))
        else $error("operation summary mismatch");
    chk_sb_low_zero: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (status_byte_o & 8'h0F) == RST_ZERO)
        else $error("status byte low bits set");
    chk_query_drops_esb: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        s_std_query ##0 s_no_new_std |=> !event_summary_bit_o)
        else $error("event query left summary set");

    // Second edge in reset: the asynchronous reset has already zeroed the event and enable registers
    chk_reset_zero: assert property (@(posedge clk_sys_i)
        !nrst_i ##1 !nrst_i |-> r.std_event_latch == RST_ZERO && r.std_enable == RST_ZERO
            && r.opr_event == RST_ZERO && r.opr_enable == RST_ZERO && r.srq_enable == RST_ZERO)
        else $error("register not zero in reset");
endmodule : sterp_core
`default_nettype wire

// ---- logic/sterp_pkg.sv ----
// Package for the status event reporting block: register layout,
// bit positions, reset values and command codes.
// Assumes a single 25 MHz system clock and a command decoder upstream.
package sterp_pkg;
    // Register width and reset value
    localparam int unsigned REG_W = 8;
    localparam logic [7:0] RST_ZERO = 8'h00;
    // Standard event bit positions
    localparam int unsigned BIT_POWER_UP  = 7;
    localparam int unsigned BIT_CMD_FAULT = 5;
    localparam int unsigned BIT_RUN_FAULT = 4;
    localparam int unsigned BIT_QRY_FAULT = 2;
    localparam int unsigned BIT_OPS_DONE  = 0;
    // Bits that can ever be set in the standard event latch
    localparam logic [7:0] STD_USED_MASK = 8'hB5;
    // Status byte positions
    localparam int unsigned SB_EVENT_SUM = 5;
    localparam int unsigned SB_OPER_SUM  = 7;
    // Decimal response: up to three digits, each 4-bit BCD
    localparam int unsigned DEC_DIGITS = 3;
    // Register selectors for queries and writes
    typedef enum logic [2:0] {
        SEL_STD_EVENT  = 3'h0,
        SEL_STD_ENABLE = 3'h1,
        SEL_OPR_EVENT  = 3'h2,
        SEL_OPR_ENABLE = 3'h3,
        SEL_OPR_COND   = 3'h4,
        SEL_SRQ_ENABLE = 3'h5,
        SEL_STAT_BYTE  = 3'h6
    } sterp_sel_t;
    // Answer sequencer states
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b01,
        ST_REPLY = 2'b10
    } sterp_state_t;
endpackage : sterp_pkg
